// File: bench/plc_calendar_clock_regs_test.sv
// Self-checking bench for the calendar clock register block.
// Assumes the block's own assertions sit in the design; the bench drives every port itself.
`timescale 1ns/1ps
module plc_calendar_clock_regs_test;
    import pcc_pkg::*;
    // Short second so a full calendar roll-over costs only a few dozen cycles
    localparam int SEC = 20;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_scan = 1'b0;
    logic i_host_off = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [15:0] i_wr_data = 16'h0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [15:0] o_rd_data;
    logic o_irq;
    int mismatches = 0;
    int checked = 0;

    // 40 MHz clock
    always #12.5 i_clk = ~i_clk;

    pcc_calendar_clock #(.SECOND_CYCLES(SEC)) uut (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_scan(i_scan), .i_host_off(i_host_off),
        .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd),
        .o_rd_data(o_rd_data), .o_irq(o_irq)
    );

    // Counts and verdict; also the exit taken when a wait runs out
    task automatic report_and_stop();
        $display("checked %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %b want %b", $time, what, got, exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    // One-cycle write strobe; one idle cycle always follows, so strobes never collide
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wr_data <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        d = o_rd_data;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp, input string what);
        logic [15:0] v;
        rd(a, v);
        chk_word(v, exp, what);
    endtask

    task automatic scan();
        @(posedge i_clk);
        i_scan <= 1'b1;
        @(posedge i_clk);
        i_scan <= 1'b0;
    endtask

    // Stage four presets, copy them on one scan, then drop the load bit at once
    task automatic load_time(input logic [15:0] w0, w1, w2, w3);
        wr(PCC_PRE_YLO_MON, w0);
        wr(PCC_PRE_DAY_HR, w1);
        wr(PCC_PRE_MIN_SEC, w2);
        wr(PCC_PRE_YHI_WDAY, w3);
        wr(PCC_CTRL, 16'h0001);
        scan();
        wr(PCC_CTRL, 16'h0000);
    endtask

    task automatic wait_irq();
        int n = 0;
        while (o_irq !== 1'b1 && n < 3 * SEC) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        if (o_irq !== 1'b1) begin
            mismatches++;
            $display("wrong value at %0t: interrupt never came", $time);
            report_and_stop();
        end
    endtask

    task automatic t_reset();
        for (int a = 0; a < 16; a++) rd_chk(4'(a), 16'h0000, "reset read");
        cycles(2 * SEC);
        rd_chk(PCC_LIVE_MIN_SEC, 16'h0000, "unset clock counted");
        chk_bit(o_irq, 1'b0, "irq after reset");
        $display("test reset done");
    endtask

    task automatic t_preset();
        wr(PCC_PRE_YLO_MON, 16'h0207);
        wr(PCC_PRE_DAY_HR, 16'h1011);
        wr(PCC_PRE_MIN_SEC, 16'h5324);
        wr(PCC_PRE_YHI_WDAY, 16'h2001);
        rd_chk(PCC_PRE_YLO_MON, 16'h0207, "preset 0");
        rd_chk(PCC_PRE_DAY_HR, 16'h1011, "preset 1");
        rd_chk(PCC_PRE_MIN_SEC, 16'h5324, "preset 2");
        rd_chk(PCC_PRE_YHI_WDAY, 16'h2001, "preset 3");
        wr(PCC_LIVE_YLO_MON, 16'hffff);
        rd_chk(PCC_LIVE_YLO_MON, 16'h0000, "live word written");
        $display("test preset done");
    endtask

    task automatic t_load();
        wr(PCC_CTRL, 16'h0001);
        scan();
        rd_chk(PCC_IRQ_STAT, 16'h0002, "load event");
        rd_chk(PCC_STATUS, 16'h0001, "valid after load");
        rd_chk(PCC_LIVE_YLO_MON, 16'h0207, "live 0");
        rd_chk(PCC_LIVE_DAY_HR, 16'h1011, "live 1");
        rd_chk(PCC_LIVE_MIN_SEC, 16'h5324, "live 2");
        rd_chk(PCC_LIVE_YHI_WDAY, 16'h2001, "live 3");
        rd_chk(PCC_CTRL, 16'h0001, "load bit readback");
        wr(PCC_PRE_MIN_SEC, 16'h1234);
        scan();
        rd_chk(PCC_LIVE_MIN_SEC, 16'h1234, "second copy");
        wr(PCC_CTRL, 16'h0000);
        wr(PCC_PRE_MIN_SEC, 16'h4321);
        scan();
        rd_chk(PCC_LIVE_MIN_SEC, 16'h1234, "copy after bit off");
        $display("test load done");
    endtask

    task automatic t_error();
        logic [15:0] v;
        load_time(16'h0213, 16'h1011, 16'h5324, 16'h2001);
        rd_chk(PCC_STATUS, 16'h0002, "bad preset status");
        rd(PCC_IRQ_STAT, v);
        chk_word(v & 16'h0006, 16'h0006, "bad preset events");
        cycles(2 * SEC);
        rd_chk(PCC_LIVE_MIN_SEC, 16'h5324, "stopped clock moved");
        load_time(16'h0207, 16'h1011, 16'h5324, 16'h2001);
        rd_chk(PCC_STATUS, 16'h0001, "error not cleared");
        $display("test error done");
    endtask

    // Load a time one second before a boundary and check the carried result
    task automatic t_roll(input logic [15:0] a0, a1, a2, a3, b0, b1, b2, b3);
        load_time(a0, a1, a2, a3);
        wr(PCC_IRQ_CLR, 16'h0007);
        wr(PCC_IRQ_EN, 16'h0001);
        cycles(1);
        wait_irq();
        rd_chk(PCC_LIVE_YLO_MON, b0, "roll year and month");
        rd_chk(PCC_LIVE_DAY_HR, b1, "roll day and hour");
        rd_chk(PCC_LIVE_MIN_SEC, b2, "roll minute and second");
        rd_chk(PCC_LIVE_YHI_WDAY, b3, "roll century and weekday");
        $display("test roll done");
    endtask

    task automatic t_irq();
        wr(PCC_IRQ_CLR, 16'h0001);
        cycles(1);
        #1;
        chk_bit(o_irq, 1'b0, "irq after clear");
        wr(PCC_IRQ_EN, 16'h0000);
        cycles(2 * SEC);
        chk_bit(o_irq, 1'b0, "masked irq");
        rd_chk(PCC_IRQ_STAT, 16'h0001, "sticky tick");
        wr(PCC_IRQ_EN, 16'h0001);
        cycles(2);
        #1;
        chk_bit(o_irq, 1'b1, "unmasked irq");
        $display("test irq done");
    endtask

    // Host off blocks the port but not the count: five ticks land while it is off
    task automatic t_host();
        load_time(16'h2401, 16'h0100, 16'h0030, 16'h2001);
        @(posedge i_clk);
        i_host_off <= 1'b1;
        cycles(3);
        rd_chk(PCC_LIVE_MIN_SEC, 16'h0000, "read while host off");
        wr(PCC_PRE_YLO_MON, 16'h9999);
        cycles(95);
        @(posedge i_clk);
        i_host_off <= 1'b0;
        cycles(3);
        rd_chk(PCC_LIVE_MIN_SEC, 16'h0035, "count while host off");
        rd_chk(PCC_PRE_YLO_MON, 16'h2401, "write taken while host off");
        $display("test host off done");
    endtask

    // A reset in mid-run must drop the running time back to unset
    task automatic t_rearm();
        @(posedge i_clk);
        i_reset_n <= 1'b0;
        cycles(16);
        i_reset_n <= 1'b1;
        rd_chk(PCC_STATUS, 16'h0000, "status after second reset");
        chk_bit(o_irq, 1'b0, "irq after second reset");
        cycles(2 * SEC);
        rd_chk(PCC_LIVE_MIN_SEC, 16'h0000, "clock counted after second reset");
        $display("test second reset done");
    endtask

    initial begin
        repeat (16) @(posedge i_clk);
        i_reset_n <= 1'b1;
        t_reset();
        t_preset();
        t_load();
        t_error();
        t_roll(16'h9912, 16'h3123, 16'h5959, 16'h2006, 16'h0001, 16'h0100, 16'h0000, 16'h2100);
        t_roll(16'h2302, 16'h2823, 16'h5959, 16'h2002, 16'h2303, 16'h0100, 16'h0000, 16'h2003);
        t_roll(16'h2402, 16'h2823, 16'h5959, 16'h2003, 16'h2402, 16'h2900, 16'h0000, 16'h2004);
        t_irq();
        t_host();
        t_rearm();
        report_and_stop();
    end
endmodule

// File: design/pcc_bcd_step.sv
// One two-digit BCD calendar field: increment with wrap from a top to a floor.
// Assumes the value is already valid BCD; purely combinational.
`timescale 1ns/1ps
module pcc_bcd_step (
    // Field in
    input wire logic [7:0] i_val,
    input wire logic [7:0] i_lo,
    input wire logic [7:0] i_hi,
    input wire logic i_inc,
    // Field out
    output logic [7:0] o_val,
    output logic o_wrap
);
    wire at_top = (i_val >= i_hi);
    wire low_nine = (i_val[3:0] == 4'h9);
    wire [7:0] bumped = low_nine ? {i_val[7:4] + 4'h1, 4'h0} : {i_val[7:4], i_val[3:0] + 4'h1};

    // Wrap reports only when an increment is really applied
    assign o_wrap = i_inc & at_top;
    assign o_val = !i_inc ? i_val : (at_top ? i_lo : bumped);
endmodule

// File: design/pcc_calendar_clock.sv
// Calendar clock register block: live BCD time words, preset words, load control.
// Assumes a controller scan pulse on i_scan and a host power pin on i_host_off.
// What this block does
// - Live time as four packed BCD words
// - Four preset words with identical BCD layout
// - Load bit copies presets into live time
// - Copy repeats each scan while bit on
// - Weekday counts 0 Sunday to 6 Saturday
// - Valid written time clears stop or error
// - Clock holds no valid time after reset
// - Keeps counting while the host is unpowered
`timescale 1ns/1ps
module pcc_calendar_clock #(
    parameter int SECOND_CYCLES = pcc_pkg::PCC_SECOND_CYCLES
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Controller scan and host power pin
    input wire logic i_scan,
    input wire logic i_host_off,
    // Register port
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rd_data,
    // Interrupt
    output logic o_irq
);
    import pcc_pkg::*;

    // BCD digit pair check against a range
    function automatic logic bcd_ok(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
        bcd_ok = (v[7:4] <= 4'h9) && (v[3:0] <= 4'h9) && (v >= lo) && (v <= hi);
    endfunction

    // Leap year from BCD century and year digits
    function automatic logic leap(input logic [7:0] yhi, input logic [7:0] ylo);
        logic [3:0] rem_lo;
        logic [3:0] rem_hi;
        rem_lo = 4'((ylo[7:4] << 1) + ylo[3:0]) & 4'h3;
        rem_hi = 4'((yhi[7:4] << 1) + yhi[3:0]) & 4'h3;
        leap = (rem_lo == 4'h0) && ((ylo != 8'h00) || (rem_hi == 4'h0));
    endfunction

    // Last day of a BCD month
    function automatic logic [7:0] month_end(input logic [7:0] mon, input logic lp);
        case (mon)
            8'h02: month_end = lp ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_end = 8'h30;
            default: month_end = 8'h31;
        endcase
    endfunction

    // Host power pin crossing; first stage feeds only the second
    // A pin edge in mid-access costs at most that one access, never half of one
    logic host_meta_r;
    logic host_off_r;
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            host_meta_r <= 1'b0;
            host_off_r <= 1'b0;
        end else begin
            host_meta_r <= i_host_off;
            host_off_r <= host_meta_r;
        end
    end

    // State
    logic [7:0] field_r [PCC_NF];
    logic [7:0] wday_r;
    logic [15:0] preset_r [4];
    logic load_r;
    logic valid_r;
    logic err_r;
    // Second counter width covers the full-rate count at 40 MHz
    logic [25:0] tick_cnt_r;
    logic [PCC_EV_W-1:0] irq_stat_r;
    logic [PCC_EV_W-1:0] irq_en_r;
    logic [15:0] rd_data_r;
    logic irq_r;

    // Bus decode; the bus is dead while the host is unpowered
    wire bus_live = !host_off_r;
    wire wr_en = i_wr && bus_live;
    wire rd_en = i_rd && bus_live;
    wire wr_ctrl = wr_en && (i_addr == PCC_CTRL);
    wire wr_clr = wr_en && (i_addr == PCC_IRQ_CLR);
    wire wr_en_reg = wr_en && (i_addr == PCC_IRQ_EN);

    // Live words as seen by software, first-named field in the upper byte
    wire [15:0] live_w [4];
    assign live_w[0] = {field_r[PCC_F_YLO], field_r[PCC_F_MON]};
    assign live_w[1] = {field_r[PCC_F_DAY], field_r[PCC_F_HOUR]};
    assign live_w[2] = {field_r[PCC_F_MIN], field_r[PCC_F_SEC]};
    assign live_w[3] = {field_r[PCC_F_YHI], wday_r};

    // Preset fields unpacked in the same layout
    wire [7:0] pre_f [PCC_NF];
    assign pre_f[PCC_F_SEC] = preset_r[2][7:0];
    assign pre_f[PCC_F_MIN] = preset_r[2][15:8];
    assign pre_f[PCC_F_HOUR] = preset_r[1][7:0];
    assign pre_f[PCC_F_DAY] = preset_r[1][15:8];
    assign pre_f[PCC_F_MON] = preset_r[0][7:0];
    assign pre_f[PCC_F_YLO] = preset_r[0][15:8];
    assign pre_f[PCC_F_YHI] = preset_r[3][15:8];
    wire [7:0] pre_wday = preset_r[3][7:0];

    // Preset check: a load of a bad date still copies but leaves the error standing
    wire pre_leap = leap(pre_f[PCC_F_YHI], pre_f[PCC_F_YLO]);
    wire preset_ok = bcd_ok(pre_f[PCC_F_SEC], 8'h00, 8'h59) && bcd_ok(pre_f[PCC_F_MIN], 8'h00, 8'h59)
        && bcd_ok(pre_f[PCC_F_HOUR], 8'h00, 8'h23) && bcd_ok(pre_f[PCC_F_MON], 8'h01, 8'h12)
        && bcd_ok(pre_f[PCC_F_DAY], 8'h01, month_end(pre_f[PCC_F_MON], pre_leap))
        && bcd_ok(pre_f[PCC_F_YLO], 8'h00, 8'h99) && bcd_ok(pre_f[PCC_F_YHI], 8'h00, 8'h99)
        && bcd_ok(pre_wday, 8'h00, PCC_WDAY_MAX);

    // Load happens on each scan while the control bit stays on
    wire load_now = load_r && i_scan;

    // One-second time base; runs from the clock's own supply
    // A load restarts the count, so the first tick after a load is a full second later
    wire tick = (tick_cnt_r == 26'(SECOND_CYCLES - 1));
    wire step = tick && valid_r && !load_now;

    // Per-field limits; the day limit follows the running month and year
    wire cur_leap = leap(field_r[PCC_F_YHI], field_r[PCC_F_YLO]);
    wire [7:0] lo_f [PCC_NF];
    wire [7:0] hi_f [PCC_NF];
    assign lo_f[PCC_F_SEC] = 8'h00;
    assign hi_f[PCC_F_SEC] = 8'h59;
    assign lo_f[PCC_F_MIN] = 8'h00;
    assign hi_f[PCC_F_MIN] = 8'h59;
    assign lo_f[PCC_F_HOUR] = 8'h00;
    assign hi_f[PCC_F_HOUR] = 8'h23;
    assign lo_f[PCC_F_DAY] = 8'h01;
    assign hi_f[PCC_F_DAY] = month_end(field_r[PCC_F_MON], cur_leap);
    assign lo_f[PCC_F_MON] = 8'h01;
    assign hi_f[PCC_F_MON] = 8'h12;
    assign lo_f[PCC_F_YLO] = 8'h00;
    assign hi_f[PCC_F_YLO] = 8'h99;
    assign lo_f[PCC_F_YHI] = 8'h00;
    assign hi_f[PCC_F_YHI] = 8'h99;

    // Carry chain through the calendar fields
    // A field wraps only when really incremented, so the carry ripples in one cycle
    wire [PCC_NF:0] carry;
    wire [7:0] next_f [PCC_NF];
    assign carry[0] = step;
    genvar g;
    generate
        for (g = 0; g < PCC_NF; g++) begin : g_field
            pcc_bcd_step u_step (
                .i_val(field_r[g]),
                .i_lo(lo_f[g]),
                .i_hi(hi_f[g]),
                .i_inc(carry[g]),
                .o_val(next_f[g]),
                .o_wrap(carry[g+1])
            );
        end
    endgenerate

    // Weekday follows the day carry, 6 back to 0
    wire wday_inc = carry[PCC_F_DAY];
    wire [7:0] wday_nxt = !wday_inc ? wday_r : ((wday_r >= PCC_WDAY_MAX) ? 8'h00 : wday_r + 8'h01);

    // Live state error: a running weekday out of range means a stopped clock
    // Defensive only: a good load cannot leave the weekday out of range
    wire live_bad = valid_r && !bcd_ok(wday_r, 8'h00, PCC_WDAY_MAX);

    // Events feeding the sticky status; set beats a same-cycle clear
    wire [PCC_EV_W-1:0] events;
    assign events[PCC_EV_SECOND] = step;
    assign events[PCC_EV_LOADED] = load_now;
    assign events[PCC_EV_ERROR] = (load_now && !preset_ok) || live_bad;
    wire [PCC_EV_W-1:0] clr_mask = wr_clr ? i_wr_data[PCC_EV_W-1:0] : PCC_IRQ_RST;
    wire [PCC_EV_W-1:0] irq_stat_nxt = (irq_stat_r & ~clr_mask) | events;

    // Read mux; unmapped and write-only offsets read as zero
    // Data come from registers only, so a read never sees a carry in flight
    wire [15:0] status_w = {14'h0000, err_r, valid_r};
    wire [15:0] rd_nxt = !rd_en ? PCC_WORD_RST :
        (i_addr <= PCC_LIVE_YHI_WDAY) ? live_w[i_addr[1:0]] :
        (i_addr <= PCC_PRE_YHI_WDAY) ? preset_r[i_addr[1:0]] :
        (i_addr == PCC_CTRL) ? {15'h0000, load_r} :
        (i_addr == PCC_STATUS) ? status_w :
        (i_addr == PCC_IRQ_STAT) ? {13'h0000, irq_stat_r} :
        (i_addr == PCC_IRQ_EN) ? {13'h0000, irq_en_r} : PCC_WORD_RST;

    // Time base counter; held at zero while a load is reloading the time
    always_ff @(posedge i_clk) begin
        if (!i_reset_n || tick || load_now) begin
            tick_cnt_r <= 26'h0000000;
        end else begin
            tick_cnt_r <= tick_cnt_r + 26'h0000001;
        end
    end

    // Live time: cleared on reset as unset, replaced by presets on load
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            for (int i = 0; i < PCC_NF; i++) begin
                field_r[i] <= PCC_FIELD_RST;
            end
            wday_r <= PCC_FIELD_RST;
        end else if (load_now) begin
            for (int i = 0; i < PCC_NF; i++) begin
                field_r[i] <= pre_f[i];
            end
            wday_r <= pre_wday;
        end else begin
            for (int i = 0; i < PCC_NF; i++) begin
                field_r[i] <= next_f[i];
            end
            wday_r <= wday_nxt;
        end
    end

    // Valid and error flags; the clock counts only after a good time is written
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            valid_r <= 1'b0;
            err_r <= 1'b0;
        end else if (load_now) begin
            valid_r <= preset_ok;
            err_r <= !preset_ok;
        end else if (live_bad) begin
            valid_r <= 1'b0;
            err_r <= 1'b1;
        end
    end

    // Preset words and the load control bit; software must clear the bit itself
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            for (int i = 0; i < 4; i++) begin
                preset_r[i] <= PCC_WORD_RST;
            end
            load_r <= 1'b0;
        end else begin
            if (wr_en && i_addr >= PCC_PRE_YLO_MON && i_addr <= PCC_PRE_YHI_WDAY) begin
                preset_r[i_addr[1:0]] <= i_wr_data;
            end
            if (wr_ctrl) begin
                load_r <= i_wr_data[PCC_CTRL_LOAD_BIT];
            end
        end
    end

    // Interrupt status, enable, output and read data
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            irq_stat_r <= PCC_IRQ_RST;
            irq_en_r <= PCC_IRQ_RST;
            irq_r <= 1'b0;
            rd_data_r <= PCC_WORD_RST;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            if (wr_en_reg) begin
                irq_en_r <= i_wr_data[PCC_EV_W-1:0];
            end
            irq_r <= |(irq_stat_nxt & (wr_en_reg ? i_wr_data[PCC_EV_W-1:0] : irq_en_r));
            rd_data_r <= rd_nxt;
        end
    end

    assign o_rd_data = rd_data_r;
    assign o_irq = irq_r;

    // Checks
    // All checks sleep during reset, where every flag they test is cleared
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    live_layout_a: assert property (rd_en && i_addr == PCC_LIVE_MIN_SEC |=>
        o_rd_data == {$past(field_r[PCC_F_MIN]), $past(field_r[PCC_F_SEC])})
        else $error("live minute second word misread");
    preset_hold_a: assert property (wr_en && i_addr == PCC_PRE_DAY_HR |=>
        preset_r[1] == $past(i_wr_data))
        else $error("preset word not stored");
    load_copy_a: assert property (load_now |=> live_w[2] == $past(preset_r[2])
        && live_w[0] == $past(preset_r[0]))
        else $error("preset not copied into live time");
    load_repeat_a: assert property (load_r && i_scan |=>
        irq_stat_r[PCC_EV_LOADED] && live_w[1] == $past(preset_r[1]))
        else $error("load not repeated on next scan");
    weekday_range_a: assert property (valid_r |-> wday_r <= PCC_WDAY_MAX)
        else $error("weekday out of range");
    error_clear_a: assert property (load_now && preset_ok |=> !err_r && valid_r)
        else $error("error not cleared by valid load");
    unset_reset_a: assert property (!$past(i_reset_n) |-> !valid_r && live_w[2] == 16'h0000)
        else $error("clock not unset after reset");
    backup_count_a: assert property (host_off_r && step |=> $past(field_r[PCC_F_SEC]) != field_r[PCC_F_SEC])
        else $error("clock stalled while host is off");
    sec_step_a: assert property (step && field_r[PCC_F_SEC][3:0] != 4'h9 |=>
        field_r[PCC_F_SEC] == $past(field_r[PCC_F_SEC]) + 8'h01)
        else $error("seconds did not step by one");
    idle_hold_a: assert property (!valid_r && !load_now |=> $stable(field_r[PCC_F_SEC]))
        else $error("unset clock advanced");

    // Read data stand one cycle only, so a late sampler sees zero, not stale data
    read_idle_a: assert property (!rd_en |=> o_rd_data == PCC_WORD_RST)
        else $error("read data outside read cycle");

    // The port is dead while the host is off; a stray write must not disturb the presets
    host_write_a: assert property (host_off_r && i_wr |=> $stable(preset_r[0]) && $stable(load_r))
        else $error("write taken while host is off");
    host_read_a: assert property (host_off_r && i_rd |=> o_rd_data == PCC_WORD_RST)
        else $error("read answered while host is off");

    // Loads: a bad preset is copied but leaves the clock stopped; only software drops the bit
    bad_load_a: assert property (load_now && !preset_ok |=> err_r && !valid_r)
        else $error("bad preset started the clock");
    load_valid_a: assert property (load_now |=> valid_r == $past(preset_ok))
        else $error("valid flag not taken from load");
    load_base_a: assert property (load_now |=> tick_cnt_r == 26'h0000000)
        else $error("time base not restarted by load");
    ctrl_hold_a: assert property (!wr_ctrl |=> $stable(load_r))
        else $error("load bit changed without a write");

    // Weekday and calendar carries
    weekday_wrap_a: assert property (wday_inc && wday_r == PCC_WDAY_MAX |=> wday_r == 8'h00)
        else $error("weekday did not wrap to zero");
    weekday_step_a: assert property (wday_inc && wday_r < PCC_WDAY_MAX |=>
        wday_r == $past(wday_r) + 8'h01)
        else $error("weekday did not step by one");
    day_wrap_a: assert property (carry[PCC_F_MON] |=> field_r[PCC_F_DAY] == 8'h01)
        else $error("day did not restart at one");
    second_flag_a: assert property (step |=> irq_stat_r[PCC_EV_SECOND])
        else $error("second tick not flagged");

    // Main scenarios the bench is meant to reach
    load_seen_c: cover property (load_now && preset_ok);
    minute_wrap_c: cover property (carry[PCC_F_MIN]);
    irq_raise_c: cover property (!o_irq ##1 o_irq);
    day_roll_c: cover property (carry[PCC_F_MON]);
    host_count_c: cover property (host_off_r && step);
endmodule

// File: design/pcc_pkg.sv
// Package for the calendar clock register block.
// Assumes a single 40 MHz clock and a plain strobe register port.
package pcc_pkg;
    // Register indexes on the plain port
    localparam logic [3:0] PCC_LIVE_YLO_MON = 4'h0;
    localparam logic [3:0] PCC_LIVE_DAY_HR = 4'h1;
    localparam logic [3:0] PCC_LIVE_MIN_SEC = 4'h2;
    localparam logic [3:0] PCC_LIVE_YHI_WDAY = 4'h3;
    localparam logic [3:0] PCC_PRE_YLO_MON = 4'h4;
    localparam logic [3:0] PCC_PRE_DAY_HR = 4'h5;
    localparam logic [3:0] PCC_PRE_MIN_SEC = 4'h6;
    localparam logic [3:0] PCC_PRE_YHI_WDAY = 4'h7;
    localparam logic [3:0] PCC_CTRL = 4'h8;
    localparam logic [3:0] PCC_STATUS = 4'h9;
    localparam logic [3:0] PCC_IRQ_STAT = 4'ha;
    localparam logic [3:0] PCC_IRQ_CLR = 4'hb;
    localparam logic [3:0] PCC_IRQ_EN = 4'hc;
    // Control and status bit positions
    localparam int PCC_CTRL_LOAD_BIT = 0;
    localparam int PCC_STAT_VALID_BIT = 0;
    localparam int PCC_STAT_ERR_BIT = 1;
    // Interrupt event bits
    localparam int PCC_EV_SECOND = 0;
    localparam int PCC_EV_LOADED = 1;
    localparam int PCC_EV_ERROR = 2;
    localparam int PCC_EV_W = 3;
    // Reset values
    localparam logic [15:0] PCC_WORD_RST = 16'h0000;
    localparam logic [7:0] PCC_FIELD_RST = 8'h00;
    localparam logic [2:0] PCC_IRQ_RST = 3'h0;
    // Time base: one second at the 25 ns clock period
    localparam longint PCC_CLK_PERIOD_PS = 25000;
    localparam longint PCC_SECOND_PS = 64'he8d4a51000;
    localparam int PCC_SECOND_CYCLES = int'(PCC_SECOND_PS / PCC_CLK_PERIOD_PS);
    // Calendar field indexes and limits (BCD)
    localparam int PCC_F_SEC = 0;
    localparam int PCC_F_MIN = 1;
    localparam int PCC_F_HOUR = 2;
    localparam int PCC_F_DAY = 3;
    localparam int PCC_F_MON = 4;
    localparam int PCC_F_YLO = 5;
    localparam int PCC_F_YHI = 6;
    localparam int PCC_NF = 7;
    localparam logic [7:0] PCC_WDAY_MAX = 8'h06;
endpackage
